// ---- design/deeac_defines.svh ----
/*
  Constants for the data EEPROM access controller: control/status field
  positions, reset value, array geometry and default phase durations.
  Assumes it is included by its bare name from the package and the module.
*/
`ifndef DEEAC_DEFINES_SVH
`define DEEAC_DEFINES_SVH
`define DEEAC_CSR_IRQ_EN_BIT 2
`define DEEAC_CSR_WM_BIT     1
`define DEEAC_CSR_PROG_BIT   0
`define DEEAC_CSR_RESET      8'h00
`define DEEAC_LATCH_COUNT    16
`define DEEAC_LOW_BITS       4
`define DEEAC_ADDR_BITS      8
`define DEEAC_ERASE_NS       2000
`define DEEAC_PROG_NS        2000
`define DEEAC_CLK_PERIOD_NS  4
`endif

// ---- design/deeac_pkg.sv ----
/*
  Types shared by the data EEPROM access controller.
  Assumes deeac_defines.svh is on the include path.
*/
`include "deeac_defines.svh"
package deeac_pkg;
  // Phases of the self-timed programming cycle.
  typedef enum logic [1:0] {
    DEEAC_IDLE,
    DEEAC_ERASE,
    DEEAC_PROG
  } deeac_phase_t;
endpackage

// ---- design/deeac_ctrl.sv ----
/*
  Data EEPROM access controller: read path, 16 row latches, control/status
  register and the self-timed erase and program cycle, with wait and halt.
  Assumes the CPU core presents one-cycle read/write strobes already decoded
  for the EEPROM area and the control register, synchronous to clk.
*/
// Overview of operation
// - Read mode returns addressed byte next cycle.
// - Data reads only; no instruction fetch.
// - Write mode writes fill sixteen latches.
// - Programming bit, written once write mode is set, programs all latched bytes; a write mode bit of 0 with it keeps write mode but clears the latches.
// - Row comes from last EEPROM write.
// - Cycle end clears both bits, interrupts.
// - Vector fetch clears pending interrupt.
// - Latches cleared at end, write-mode fall.
// - Repeated writes program the AND.
// - Latched data cannot be read back.
// - Internally timed erase then program phases.
// - Wait entered after cycle completes.
// - Halt aborts cycle immediately.
// - Reads undriven in write mode; writes ignored in read mode.
// - Control bits 2..0, upper bits zero.
// - Write mode clears by software only when not programming.
`include "deeac_defines.svh"
module deeac_ctrl #(
  parameter int ADDR_W   = `DEEAC_ADDR_BITS,
  parameter int ERASE_CY = (`DEEAC_ERASE_NS + `DEEAC_CLK_PERIOD_NS - 1) / `DEEAC_CLK_PERIOD_NS,
  parameter int PROG_CY  = (`DEEAC_PROG_NS + `DEEAC_CLK_PERIOD_NS - 1) / `DEEAC_CLK_PERIOD_NS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] mem_addr,        // Byte address inside the EEPROM area.
  input  wire logic              mem_rd,          // Data read strobe.
  input  wire logic              mem_fetch,       // Opcode fetch strobe, never served.
  input  wire logic              mem_wr,          // Write strobe.
  input  wire logic [7:0]        mem_wdata,       // Write data.
  output logic      [7:0]        mem_rdata,       // Read data.
  output logic                   mem_rdata_oe,    // High while the block drives read data.
  input  wire logic              csr_wr,          // Control register write strobe.
  input  wire logic [7:0]        csr_wdata,       // Control register write data.
  output logic      [7:0]        eeprom_control_status, // Control register value.
  input  wire logic              vector_fetch,    // CPU fetches the EEPROM vector.
  output logic                   irq,             // Pending interrupt request.
  input  wire logic              wait_for_interrupt_instr, // Wait request.
  output logic                   wait_ack,        // Block is in wait mode.
  input  wire logic              halt_req,        // Halt instruction, level.
  output logic                   halt_ack         // Block is halted.
);

  localparam int CNT_W = $clog2((ERASE_CY > PROG_CY ? ERASE_CY : PROG_CY) + 1);
  localparam int NUM_LATCH = `DEEAC_LATCH_COUNT;
  localparam int LOW_W     = `DEEAC_LOW_BITS;
  localparam int ROW_W     = ADDR_W - LOW_W;

  logic [7:0]            array_r [2**ADDR_W];  // The nonvolatile array.
  logic [7:0]            latch_r [NUM_LATCH];  // Row data latches.
  logic [NUM_LATCH-1:0]  used_r;               // Latches written since last clear.
  logic [ROW_W-1:0]      row_r;                // Row of the latest write.
  logic                  irq_en_r;             // eeprom_irq_enable.
  logic                  wm_r;                 // write_mode_select.
  logic                  prog_r;               // program_cycle_active.
  logic                  irq_r;                // Pending interrupt.
  logic                  wait_r;               // Wait mode entered.
  deeac_pkg::deeac_phase_t phase_r;           // Cycle phase.
  logic [CNT_W-1:0]      cnt_r;                // Phase cycle counter.
  logic                  done;                 // Last cycle of program phase.
  logic                  start;                // Software starts a cycle.
  logic                  wm_clear;             // Software drops write mode.
  logic                  abort;                // Halt cuts a running cycle.

  // Row address bits of an address.
  function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:LOW_W];
  endfunction

  assign done  = (phase_r == deeac_pkg::DEEAC_PROG) && (cnt_r == CNT_W'(PROG_CY - 1)) && !halt_req;
  // Starting needs write mode already set, so one control write cannot both select write mode and start.
  assign start = csr_wr && csr_wdata[`DEEAC_CSR_PROG_BIT] && wm_r && !prog_r && !halt_req;
  assign wm_clear = csr_wr && !csr_wdata[`DEEAC_CSR_WM_BIT] && wm_r && !prog_r;
  // A halt during a running cycle drops write mode too, so it counts as a falling edge for the latches.
  assign abort = halt_req && prog_r;

  // Control/status bits; hardware end of cycle and halt abort win over software.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_r <= 1'b0;
      wm_r     <= 1'b0;
      prog_r   <= 1'b0;
    end else begin
      if (csr_wr) begin
        irq_en_r <= csr_wdata[`DEEAC_CSR_IRQ_EN_BIT];
      end
      if (done || abort) begin
        wm_r   <= 1'b0;
        prog_r <= 1'b0;
      end else if (start) begin
        prog_r <= 1'b1;
      end else if (csr_wr && !prog_r) begin
        wm_r <= csr_wdata[`DEEAC_CSR_WM_BIT];
      end
    end
  end

  assign eeprom_control_status = {5'h00, irq_en_r, wm_r, prog_r};

  // Phase sequencer: erase then program, counted in clock cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= deeac_pkg::DEEAC_IDLE;
      cnt_r   <= '0;
    end else if (halt_req) begin
      phase_r <= deeac_pkg::DEEAC_IDLE;
      cnt_r   <= '0;
    end else begin
      case (phase_r)
        deeac_pkg::DEEAC_IDLE: begin
          cnt_r <= '0;
          if (start) begin
            phase_r <= deeac_pkg::DEEAC_ERASE;
          end
        end
        deeac_pkg::DEEAC_ERASE: begin
          if (cnt_r == CNT_W'(ERASE_CY - 1)) begin
            phase_r <= deeac_pkg::DEEAC_PROG;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        deeac_pkg::DEEAC_PROG: begin
          if (done) begin
            phase_r <= deeac_pkg::DEEAC_IDLE;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          phase_r <= deeac_pkg::DEEAC_IDLE;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // Row latches; an un-cleared latch keeps ANDing in new data.
  // Every fall of write mode clears them, whether software, cycle end or halt drops it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      used_r <= '0;
      row_r  <= '0;
      for (int i = 0; i < NUM_LATCH; i++) begin
        latch_r[i] <= 8'hFF;
      end
    end else if (done || wm_clear || abort) begin
      used_r <= '0;
      for (int i = 0; i < NUM_LATCH; i++) begin
        latch_r[i] <= 8'hFF;
      end
    end else if (mem_wr && wm_r && !prog_r) begin
      used_r[mem_addr[LOW_W-1:0]]  <= 1'b1;
      latch_r[mem_addr[LOW_W-1:0]] <= latch_r[mem_addr[LOW_W-1:0]] & mem_wdata;
      row_r <= row_of(mem_addr);
    end
  end

  // Array update; the erase is modelled as overwrite, so only the result is visible.
  // A halted cycle leaves the array untouched here, real cells may be corrupt.
  always_ff @(posedge clk) begin
    if (done) begin
      for (int i = 0; i < NUM_LATCH; i++) begin
        if (used_r[i]) begin
          array_r[{row_r, LOW_W'(i)}] <= latch_r[i];
        end
      end
    end
  end

  // Read port: array only, never the latches, only in read mode, no fetches.
  // A refused fetch leaves the last served byte in place rather than leaking code.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd && !mem_fetch && !wm_r) begin
      mem_rdata <= array_r[mem_addr];
    end
  end
  logic rd_oe_r; // Read data valid the cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_oe_r <= 1'b0;
    end else begin
      rd_oe_r <= mem_rd && !mem_fetch && !wm_r;
    end
  end
  assign mem_rdata_oe = rd_oe_r;

  // Interrupt: set on completion wins over vector fetch clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (done && irq_en_r) begin
      irq_r <= 1'b1;
    end else if (vector_fetch) begin
      irq_r <= 1'b0;
    end
  end
  assign irq = irq_r;

  // Wait waits for the cycle; halt is immediate.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b0;
    end else if (wait_for_interrupt_instr && !prog_r) begin
      wait_r <= 1'b1;
    end else if (!wait_for_interrupt_instr) begin
      wait_r <= 1'b0;
    end
  end
  assign wait_ack = wait_r;
  assign halt_ack = halt_req;

  a_irq_on_done: assert property (@(posedge clk) disable iff (rst)
    done && irq_en_r |=> irq) else $error("no irq after cycle end");
  a_bits_clear: assert property (@(posedge clk) disable iff (rst)
    done |=> !prog_r && !wm_r) else $error("bits not cleared");
  a_latch_clear: assert property (@(posedge clk) disable iff (rst)
    done || wm_clear || abort |=> used_r == '0) else $error("latches not cleared");
  a_vec_clear: assert property (@(posedge clk) disable iff (rst)
    vector_fetch && !done && irq |=> !irq) else $error("irq not cleared");
  a_no_drive_wm: assert property (@(posedge clk) disable iff (rst)
    mem_rd && wm_r |=> !mem_rdata_oe) else $error("drove bus in write mode");
  a_read_oe: assert property (@(posedge clk) disable iff (rst)
    mem_rd && !mem_fetch && !wm_r |=> mem_rdata_oe) else $error("read not served");
  a_no_fetch: assert property (@(posedge clk) disable iff (rst)
    mem_fetch |=> !mem_rdata_oe) else $error("fetch served");
  a_prog_held: assert property (@(posedge clk) disable iff (rst)
    phase_r != deeac_pkg::DEEAC_IDLE |-> prog_r) else $error("program bit dropped");
  a_erase_first: assert property (@(posedge clk) disable iff (rst || halt_req)
    start |=> phase_r == deeac_pkg::DEEAC_ERASE) else $error("no erase");
  a_wm_hold: assert property (@(posedge clk) disable iff (rst)
    prog_r && !done && !halt_req |=> wm_r) else $error("wm dropped");
  a_halt_abort: assert property (@(posedge clk) disable iff (rst)
    halt_req |=> phase_r == deeac_pkg::DEEAC_IDLE) else $error("halt ignored");
  a_wait_busy: assert property (@(posedge clk) disable iff (rst)
    prog_r && !wait_ack |=> !wait_ack) else $error("wait too early");
  a_csr_zero: assert property (@(posedge clk) disable iff (rst)
    eeprom_control_status[7:3] == 5'h00) else $error("reserved bits set");

endmodule

// ---- tb/deeac_cpu_model.sv ----
/*
  CPU core bus model facing the EEPROM controller: control and EEPROM strobes.
  Assumes the controller samples every strobe at the rising edge of clk.
*/
module deeac_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       mem_rdata_oe,
  output logic      [7:0] mem_addr,
  output logic            mem_rd,
  output logic            mem_fetch,
  output logic            mem_wr,
  output logic      [7:0] mem_wdata,
  output logic            csr_wr,
  output logic      [7:0] csr_wdata,
  output logic            vector_fetch,
  output logic            wait_for_interrupt_instr,
  output logic            halt_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero; no request leaves before the first edge.
  initial begin
    mem_addr                 = 8'h00;
    mem_rd                   = 1'b0;
    mem_fetch                = 1'b0;
    mem_wr                   = 1'b0;
    mem_wdata                = 8'h00;
    csr_wr                   = 1'b0;
    csr_wdata                = 8'h00;
    vector_fetch             = 1'b0;
    wait_for_interrupt_instr = 1'b0;
    halt_req                 = 1'b0;
  end
  // Wait and halt are levels the core holds while it sits in that instruction.
  task automatic wait_instr(input logic v);
    @(posedge clk);
    wait_for_interrupt_instr <= v;
  endtask
  task automatic halt(input logic v);
    @(posedge clk);
    halt_req <= v;
  endtask
  // Released data lines flip so a stale value is never mistaken for a fresh one.
  task automatic csr(input logic [7:0] v);
    @(posedge clk);
    csr_wr <= 1'b1;
    csr_wdata <= v;
    @(posedge clk);
    csr_wr <= 1'b0;
    csr_wdata <= ~v;
  endtask
  // Callers keep the upper address bits fixed between two programming cycles.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_wdata <= ~d;
  endtask
  // Two back-to-back reads; the first value is discarded, the second returned.
  task automatic rd2(input logic [7:0] a, input logic f, output logic [7:0] d,
                     output logic oe);
    @(posedge clk);
    mem_rd <= 1'b1;
    mem_fetch <= f;
    mem_addr <= a;
    @(posedge clk);
    @(posedge clk);
    mem_rd <= 1'b0;
    mem_fetch <= 1'b0;
    #1;
    d = mem_rdata;
    oe = mem_rdata_oe;
  endtask
  // Vector fetch pulse as the interrupt controller would give it.
  task automatic vec();
    @(posedge clk);
    vector_fetch <= 1'b1;
    @(posedge clk);
    vector_fetch <= 1'b0;
  endtask
endmodule

// ---- tb/deeac_ctrl_tb.sv ----
/*
  Self-checking bench for the EEPROM controller, phases shortened to 4 cycles.
  Assumes the CPU model supplies every bus strobe.
*/
module deeac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;               // Bench clock, 4 ns period.
  logic       rst;                      // Asynchronous reset, active high.
  logic       wait_for_interrupt_instr; // Wait level from the core model.
  logic       halt_req;                 // Halt level from the core model.
  logic [7:0] mem_addr;                 // EEPROM byte address.
  logic [7:0] mem_wdata;                // EEPROM write data.
  logic [7:0] csr_wdata;                // Control register write data.
  logic [7:0] mem_rdata;                // Read data from the controller.
  logic [7:0] csr;                      // Control/status value.
  logic       mem_rd;
  logic       mem_fetch;
  logic       mem_wr;
  logic       csr_wr;
  logic       vector_fetch;
  logic       mem_rdata_oe;
  logic       irq;
  logic       wait_ack;
  logic       halt_ack;
  logic [7:0] d;                        // Byte kept from a double read.
  logic       oe;                       // Drive flag seen on that read.
  int         n_errors = 0;
  int         n_compared = 0;
  int         n;                        // Cycles waited for the program bit.
  always #2 clk = ~clk;
  deeac_cpu_model cpu (.clk(clk), .mem_rdata(mem_rdata), .mem_rdata_oe(mem_rdata_oe),
    .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_fetch(mem_fetch), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .csr_wr(csr_wr), .csr_wdata(csr_wdata), .vector_fetch(vector_fetch),
    .wait_for_interrupt_instr(wait_for_interrupt_instr), .halt_req(halt_req));
  deeac_ctrl #(.ERASE_CY(4), .PROG_CY(4)) dut (.clk(clk), .rst(rst),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_fetch(mem_fetch), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rdata_oe(mem_rdata_oe),
    .csr_wr(csr_wr), .csr_wdata(csr_wdata), .eeprom_control_status(csr),
    .vector_fetch(vector_fetch), .irq(irq),
    .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .wait_ack(wait_ack), .halt_req(halt_req), .halt_ack(halt_ack));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Counts cycles until the program bit drops; a hang counts as a mismatch.
  task automatic wait_prog();
    for (n = 1; n <= 50; n++) begin
      @(posedge clk);
      #1;
      if (csr[0] === 1'b0) return;
    end
    n_errors++;
    $display("[ERR] %0t programming cycle never ended", $time);
    summarize();
  endtask
  // Full cycle with repeated writes, refused clear, wait request and interrupt.
  // Wait is raised only once the cycle runs, so the busy case is what gets tested.
  task automatic t_program();
    cpu.csr(8'h02);
    cpu.wr(8'h35, 8'h5A);
    cpu.wr(8'h35, 8'hF0);
    cpu.wr(8'h3A, 8'h11);
    cpu.csr(8'h07);
    #1;
    chk(csr, 8'h07);
    cpu.wait_instr(1'b1);
    cpu.csr(8'h04);
    #1;
    chk(csr, 8'h07);
    chk({7'h00, wait_ack}, 8'h00);
    wait_prog();
    chk(8'(n + 3), 8'h08);
    chk(csr, 8'h04);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, wait_ack}, 8'h01);
    cpu.wait_instr(1'b0);
    cpu.vec();
    #1;
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, wait_ack}, 8'h00);
    cpu.rd2(8'h35, 1'b0, d, oe);
    chk(d, 8'h50);
    chk({7'h00, oe}, 8'h01);
    cpu.rd2(8'h3A, 1'b0, d, oe);
    chk(d, 8'h11);
  endtask
  // Refused accesses and latch clearing on a software write-mode fall.
  task automatic t_refuse();
    cpu.wr(8'h35, 8'h00);
    cpu.csr(8'h02);
    cpu.wr(8'h35, 8'h00);
    cpu.rd2(8'h35, 1'b0, d, oe);
    chk({7'h00, oe}, 8'h00);
    cpu.csr(8'h00);
    cpu.csr(8'h02);
    cpu.wr(8'h36, 8'hAA);
    cpu.csr(8'h03);
    wait_prog();
    chk({7'h00, irq}, 8'h00);
    cpu.rd2(8'h35, 1'b0, d, oe);
    chk(d, 8'h50);
    cpu.rd2(8'h36, 1'b1, d, oe);
    chk({7'h00, oe}, 8'h00);
    chk(d, 8'h50);
    cpu.rd2(8'h36, 1'b0, d, oe);
    chk(d, 8'hAA);
  endtask
  // Halt in mid-cycle stops it at once and drops the latched data with write mode.
  task automatic t_halt();
    cpu.csr(8'h02);
    cpu.wr(8'h37, 8'h3C);
    cpu.csr(8'h03);
    cpu.halt(1'b1);
    #1;
    chk({7'h00, halt_ack}, 8'h01);
    @(posedge clk);
    #1;
    chk(csr, 8'h00);
    cpu.halt(1'b0);
    cpu.csr(8'h02);
    cpu.wr(8'h37, 8'hC3);
    cpu.csr(8'h03);
    wait_prog();
    cpu.rd2(8'h37, 1'b0, d, oe);
    chk(d, 8'hC3);
  endtask
  // Reset for three edges, then the scenarios in turn.
  initial begin
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(csr, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    t_program();
    t_refuse();
    t_halt();
    summarize();
  end
endmodule
